// file: src/sptc_top.sv
// Purpose: Prescalers, clock selection, control registers, dead zone and DMA select
// Assumes: External clock pins are synchronous to clk_i
// Notes: Read data is registered and valid one cycle after the strobe
//
// The address-and-strobe port was chosen for this implementation.

// Summary of operation
// - Tick rate is clock over prescaler plus one over selected divider
// - Dead zone length field in top byte counts timer 0 ticks
// - Three prescaler bytes serve timer pairs 0-1, 2-3, 4-5
// - DMA field picks none or timers 0 to 5; codes 7 to 15 reserved
// - Clock select codes 0 to 3 give divide by 2, 4, 8, 16
// - Timers 0 to 3 use divide by 32 for codes 01xx
// - Timer 4 uses external timer clock for codes 01xx
// - Timer 5 uses second external clock for codes 01xx
// - Auto-reload bit picks one-shot or interval operation
// - Manual update on timers 0-4 loads counter and compare
// - Manual update on timer 5 loads only its counter
// - Run bit starts and stops each timer
// - Inversion bit inverts timers 0-4 output pins, except pin 1 with dead zone on, which carries the timer 0 complement
// - Control bit 4 enables dead zone insertion on timer 0
// - Configuration and control registers reset to zero
// - Timer chosen for DMA raises no interrupt; others do
// - At zero reload in interval mode, else hold and stop
// - Output goes high on compare match until reload
// - Dead zone keeps output and complement never active together
module sptc_top
	import sptc_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int CNT_W = 16
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	input wire logic external_timer_clock_i,
	input wire logic external_clock_input_i,
	input wire logic dma_ack_i,
	output logic dma_req_o,
	output logic [SPTC_NUM_TIMERS-1:0] irq_o,
	output logic [SPTC_NUM_PWM-1:0] pwm_output_pin_o,
	output logic complementary_pwm_output_o
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	generate
		if (ADDR_W != 32 || CNT_W < 2 || CNT_W > 32)
		begin : g_bad_param
			$error("sptc_top: ADDR_W must be 32 and CNT_W within 2 to 32");
		end
	endgenerate

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] prescale_reg;
	logic [31:0] clksel_reg;
	logic [31:0] ctrl_reg;
	logic [CNT_W-1:0] cnt_buf_reg [SPTC_NUM_TIMERS];
	logic [CNT_W-1:0] cmp_buf_reg [SPTC_NUM_TIMERS];
	logic [CNT_W-1:0] count [SPTC_NUM_TIMERS];
	logic [31:0] rd_next;
	logic [31:0] rd_data_reg;
	logic [SPTC_NUM_TIMERS-1:0] hit_cnt;
	logic [SPTC_NUM_TIMERS-1:0] hit_cmp;
	logic [SPTC_NUM_TIMERS-1:0] hit_obs;

	always_comb
	begin
		for (int n = 0; n < SPTC_NUM_TIMERS; n++)
		begin
			hit_cnt[n] = addr_i == 32'(SPTC_OFS_CNTBUF0 + SPTC_TIMER_STRIDE * n);
			hit_cmp[n] = (n != SPTC_EXT2_TIMER) &&
				(addr_i == 32'(SPTC_OFS_CNTBUF0 + SPTC_TIMER_STRIDE * n + SPTC_OFS_CMPBUF_DELTA));
			hit_obs[n] = addr_i == 32'(SPTC_OFS_CNTBUF0 + SPTC_TIMER_STRIDE * n + SPTC_OFS_OBS_DELTA);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prescale_reg <= SPTC_RESET_VALUE;
			clksel_reg <= SPTC_RESET_VALUE;
		end
		else if (wr_en_i)
		begin
			if (addr_i == SPTC_OFS_PRESCALE)
				prescale_reg <= wr_data_i;
			if (addr_i == SPTC_OFS_CLKSEL)
				clksel_reg <= wr_data_i & SPTC_CLKSEL_WR_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_reg <= SPTC_RESET_VALUE;
		else if (wr_en_i && addr_i == SPTC_OFS_CONTROL)
			ctrl_reg <= wr_data_i & SPTC_CONTROL_WR_MASK;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int n = 0; n < SPTC_NUM_TIMERS; n++)
			begin
				cnt_buf_reg[n] <= '0;
				cmp_buf_reg[n] <= '0;
			end
		end
		else if (wr_en_i)
		begin
			for (int n = 0; n < SPTC_NUM_TIMERS; n++)
			begin
				if (hit_cnt[n])
					cnt_buf_reg[n] <= wr_data_i[CNT_W-1:0];
				if (hit_cmp[n])
					cmp_buf_reg[n] <= wr_data_i[CNT_W-1:0];
			end
		end
	end

	// Unmapped addresses read zero
	always_comb
	begin
		rd_next = SPTC_RD_NONE;
		if (addr_i == SPTC_OFS_PRESCALE)
			rd_next = prescale_reg;
		if (addr_i == SPTC_OFS_CLKSEL)
			rd_next = clksel_reg;
		if (addr_i == SPTC_OFS_CONTROL)
			rd_next = ctrl_reg;
		for (int n = 0; n < SPTC_NUM_TIMERS; n++)
		begin
			if (hit_cnt[n])
				rd_next = 32'(cnt_buf_reg[n]);
			if (hit_cmp[n])
				rd_next = 32'(cmp_buf_reg[n]);
			if (hit_obs[n])
				rd_next = 32'(count[n]);
		end
	end

	// Data holds only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_data_reg <= SPTC_RD_NONE;
		else if (rd_en_i)
			rd_data_reg <= rd_next;
		else
			rd_data_reg <= SPTC_RD_NONE;
	end
	assign rd_data_o = rd_data_reg;

	// ------------------------------------------------------------
	// Prescalers and dividers
	// ------------------------------------------------------------
	logic [SPTC_PRESC_W-1:0] pre_cnt_reg [SPTC_NUM_GROUPS];
	logic [SPTC_DIV_W-1:0] div_cnt_reg [SPTC_NUM_GROUPS];
	logic [SPTC_NUM_GROUPS-1:0] pre_tick;
	logic [SPTC_DIV_W-1:0] div_tick [SPTC_NUM_GROUPS];
	logic [SPTC_PRESC_W-1:0] presc [SPTC_NUM_GROUPS];

	genvar g, k;
	generate
		for (g = 0; g < SPTC_NUM_GROUPS; g++)
		begin : g_grp
			// One prescaler byte per timer pair
			assign presc[g] = prescale_reg[SPTC_PRESC_LSB[g] +: SPTC_PRESC_W];
			assign pre_tick[g] = pre_cnt_reg[g] == presc[g];

			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					pre_cnt_reg[g] <= '0;
				else if (pre_tick[g] || pre_cnt_reg[g] > presc[g])
					pre_cnt_reg[g] <= '0;
				else
					pre_cnt_reg[g] <= pre_cnt_reg[g] + 1'b1;
			end

			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					div_cnt_reg[g] <= '0;
				else if (pre_tick[g])
					div_cnt_reg[g] <= div_cnt_reg[g] + 1'b1;
			end

			// Divide by two to the k plus one
			for (k = 0; k < SPTC_DIV_W; k++)
			begin : g_div
				assign div_tick[g][k] = pre_tick[g] && (&div_cnt_reg[g][k:0]);
			end

			a_presc_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(pre_tick[g] && presc[g] != '0 && $stable(presc[g])) |=> !pre_tick[g])
				else $error("prescaler ticked twice with nonzero value");
		end
	endgenerate

	// ------------------------------------------------------------
	// Per-timer clock selection
	// ------------------------------------------------------------
	logic [1:0] ext_prev_reg;
	logic [1:0] ext_tick;
	logic [SPTC_NUM_TIMERS-1:0] timer_tick;

	// Pins are synchronous, so one flop suffices for the edge
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ext_prev_reg <= 2'h0;
		else
			ext_prev_reg <= {external_clock_input_i, external_timer_clock_i};
	end
	assign ext_tick = {external_clock_input_i, external_timer_clock_i} & ~ext_prev_reg;

	always_comb
	begin
		logic [SPTC_MUX_W-1:0] code;
		code = '0;
		timer_tick = '0;
		for (int n = 0; n < SPTC_NUM_TIMERS; n++)
		begin
			code = clksel_reg[n*SPTC_MUX_W +: SPTC_MUX_W];
			unique case (sptc_mux_t'(code[3:2]))
				// Codes 0 to 3 pick fixed dividers
				SPTC_MUX_DIV: timer_tick[n] = div_tick[n/2][code[1:0]];
				SPTC_MUX_ALT:
				begin
					if (n == SPTC_EXT_TIMER)
						timer_tick[n] = ext_tick[0];
					else if (n == SPTC_EXT2_TIMER)
						timer_tick[n] = ext_tick[1];
					else
						timer_tick[n] = div_tick[n/2][SPTC_DIV32_IDX];
				end
				// Undefined upper codes fall back to the slowest internal rate
				SPTC_MUX_HI0, SPTC_MUX_HI1: timer_tick[n] = div_tick[n/2][SPTC_DIV32_IDX];
			endcase
		end
	end

	// ------------------------------------------------------------
	// Timer channels
	// ------------------------------------------------------------
	logic [SPTC_NUM_TIMERS-1:0] tout_raw;
	logic [SPTC_NUM_TIMERS-1:0] zero;
	logic [SPTC_NUM_TIMERS-1:0] dma_sel;
	logic [SPTC_NUM_TIMERS-1:0] irq_reg;
	logic [SPTC_NUM_PWM-1:0] tout_inv;
	logic dma_req_reg;

	genvar n;
	generate
		for (n = 0; n < SPTC_NUM_TIMERS; n++)
		begin : g_tmr
			sptc_chan #(
				.CNT_W(CNT_W),
				.HAS_CMP(n != SPTC_EXT2_TIMER)
			) u_chan (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.tick_i(timer_tick[n]),
				.run_i(ctrl_reg[SPTC_RUN_BIT[n]]),
				.auto_reload_i(ctrl_reg[SPTC_AR_BIT[n]]),
				.manual_update_i(ctrl_reg[SPTC_UPD_BIT[n]]),
				.count_buffer_i(cnt_buf_reg[n]),
				.compare_buffer_i(cmp_buf_reg[n]),
				.count_o(count[n]),
				.tout_o(tout_raw[n]),
				.zero_o(zero[n])
			);

			// Code n plus one picks timer n
			assign dma_sel[n] = clksel_reg[SPTC_DMA_LSB +: SPTC_DMA_W] == 4'(SPTC_DMA_TIMER0 + n);

			// Manual update copies the count buffer
			a_update_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				ctrl_reg[SPTC_UPD_BIT[n]] |=> count[n] == $past(cnt_buf_reg[n]))
				else $error("manual update did not load counter");
			// Selected timer goes to DMA only
			a_dma_no_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(zero[n] && dma_sel[n]) |=> (dma_req_reg && !irq_reg[n]))
				else $error("DMA timer raised an interrupt");
			a_zero_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(zero[n] && !dma_sel[n]) |=> irq_reg[n])
				else $error("zero reached without interrupt");
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_reg <= '0;
		else
			irq_reg <= zero & ~dma_sel;
	end
	assign irq_o = irq_reg;

	// Held until acknowledged; a new event wins over the acknowledge
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dma_req_reg <= 1'b0;
		else if (|(zero & dma_sel))
			dma_req_reg <= 1'b1;
		else if (dma_ack_i)
			dma_req_reg <= 1'b0;
	end
	assign dma_req_o = dma_req_reg;

	a_dma_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(dma_req_reg && !dma_ack_i) |=> dma_req_reg)
		else $error("DMA request dropped without acknowledge");

	// ------------------------------------------------------------
	// Inversion and dead zone
	// ------------------------------------------------------------
	logic dz_en;
	logic [SPTC_DZ_W-1:0] dz_len;
	logic [SPTC_DZ_W-1:0] dz_cnt_reg;
	logic [SPTC_DZ_W-1:0] dz_cnt_next;
	logic dz_prev_reg;
	logic dz_out_reg;
	logic dz_comp_reg;
	logic [SPTC_NUM_PWM-1:0] pin_reg;
	logic comp_pin_reg;

	always_comb
	begin
		for (int i = 0; i < SPTC_NUM_PWM; i++)
			tout_inv[i] = tout_raw[i] ^ ctrl_reg[SPTC_INV_BIT[i]];
	end

	assign dz_en = ctrl_reg[SPTC_DZ_EN_BIT];
	// Gap length in timer 0 ticks
	assign dz_len = prescale_reg[SPTC_DZ_LSB +: SPTC_DZ_W];

	always_comb
	begin
		if (tout_inv[0] != dz_prev_reg)
			dz_cnt_next = dz_len;
		else if (dz_cnt_reg != '0 && timer_tick[0])
			dz_cnt_next = dz_cnt_reg - 1'b1;
		else
			dz_cnt_next = dz_cnt_reg;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dz_prev_reg <= 1'b0;
			dz_cnt_reg <= '0;
		end
		else
		begin
			dz_prev_reg <= tout_inv[0];
			dz_cnt_reg <= dz_cnt_next;
		end
	end

	// Both held low during the gap
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dz_out_reg <= 1'b0;
			dz_comp_reg <= 1'b0;
		end
		else
		begin
			dz_out_reg <= tout_inv[0] && dz_cnt_next == '0;
			dz_comp_reg <= !tout_inv[0] && dz_cnt_next == '0;
		end
	end

	// Dead zone routes complement to timer 1 pin
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_reg <= '0;
			comp_pin_reg <= 1'b0;
		end
		else
		begin
			pin_reg <= tout_inv;
			comp_pin_reg <= !tout_inv[0];
			if (dz_en)
			begin
				pin_reg[0] <= dz_out_reg;
				pin_reg[1] <= dz_comp_reg;
				comp_pin_reg <= dz_comp_reg;
			end
		end
	end
	assign pwm_output_pin_o = pin_reg;
	assign complementary_pwm_output_o = comp_pin_reg;

	sequence s_dz_edge;
		tout_inv[0] != dz_prev_reg && dz_len != '0;
	endsequence

	sequence s_dz_gap;
		!dz_out_reg && !dz_comp_reg;
	endsequence

	a_dz_gap_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_dz_edge |=> s_dz_gap)
		else $error("dead zone gap not inserted");
	a_dz_exclusive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!(dz_out_reg && dz_comp_reg))
		else $error("dead zone outputs active together");
	a_inv_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> pin_reg[2] == $past(tout_raw[2] ^ ctrl_reg[SPTC_INV_BIT[2]]))
		else $error("timer 2 pin inversion wrong");
	a_ctrl_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl_reg & ~SPTC_CONTROL_WR_MASK) == '0)
		else $error("reserved control bit set");
	a_div32_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		div_tick[0][SPTC_DIV32_IDX] |-> (pre_tick[0] && div_cnt_reg[0] == '1))
		else $error("divide by 32 tick off its count");
	a_t4_ext: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(clksel_reg[SPTC_EXT_TIMER*SPTC_MUX_W+2 +: 2] == SPTC_MUX_ALT) |-> timer_tick[SPTC_EXT_TIMER] == ext_tick[0])
		else $error("timer 4 not on external clock");
endmodule

// file: src/sptc_pkg.sv
// Purpose: Shared constants for the six channel timer control block
// Assumes: 32-bit register port, byte addresses as printed
// Notes: Per-timer bit positions are tables indexed by timer number
package sptc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [31:0] SPTC_OFS_PRESCALE = 32'h01d5_0000;
	localparam logic [31:0] SPTC_OFS_CLKSEL = 32'h01d5_0004;
	localparam logic [31:0] SPTC_OFS_CONTROL = 32'h01d5_0008;
	localparam logic [31:0] SPTC_OFS_CNTBUF0 = 32'h01d5_000c;
	localparam logic [31:0] SPTC_OFS_CMPBUF_DELTA = 32'h0000_0004;
	localparam logic [31:0] SPTC_OFS_OBS_DELTA = 32'h0000_0008;
	localparam logic [31:0] SPTC_TIMER_STRIDE = 32'h0000_000c;
	localparam logic [31:0] SPTC_RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] SPTC_CONTROL_WR_MASK = 32'h07ff_ff1f;
	localparam logic [31:0] SPTC_CLKSEL_WR_MASK = 32'h0fff_ffff;
	localparam logic [31:0] SPTC_RD_NONE = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int SPTC_NUM_TIMERS = 6;
	localparam int SPTC_NUM_PWM = 5;
	localparam int SPTC_NUM_GROUPS = 3;
	localparam int SPTC_PRESC_W = 8;
	localparam int SPTC_PRESC_LSB [3] = '{0, 8, 16};
	localparam int SPTC_DZ_LSB = 24;
	localparam int SPTC_DZ_W = 8;
	localparam int SPTC_MUX_W = 4;
	localparam int SPTC_DMA_LSB = 24;
	localparam int SPTC_DMA_W = 4;
	localparam int SPTC_DIV_W = 5;
	localparam int SPTC_DZ_EN_BIT = 4;
	localparam int SPTC_RUN_BIT [6] = '{0, 8, 12, 16, 20, 24};
	localparam int SPTC_UPD_BIT [6] = '{1, 9, 13, 17, 21, 25};
	localparam int SPTC_INV_BIT [5] = '{2, 10, 14, 18, 22};
	localparam int SPTC_AR_BIT [6] = '{3, 11, 15, 19, 23, 26};
	localparam int SPTC_EXT_TIMER = 4;
	localparam int SPTC_EXT2_TIMER = 5;
	localparam int SPTC_DIV32_IDX = 4;
	localparam int SPTC_FIRST_DIV_TIMER_MAX = 3;

	// DMA channel codes: none, then timer n at code n+1
	localparam logic [3:0] SPTC_DMA_NONE = 4'h0;
	localparam logic [3:0] SPTC_DMA_TIMER0 = 4'h1;

	// Upper two bits of a clock select code
	typedef enum logic [1:0] {
		SPTC_MUX_DIV = 2'b00,
		SPTC_MUX_ALT = 2'b01,
		SPTC_MUX_HI0 = 2'b10,
		SPTC_MUX_HI1 = 2'b11
	} sptc_mux_t;
endpackage

// file: src/sptc_chan.sv
// Purpose: One down counter with compare and an output set on match
// Assumes: tick_i is a one-cycle pulse at the selected rate
// Notes: Manual update acts as a level while the bit is held
module sptc_chan
	import sptc_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter bit HAS_CMP = 1'b1
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic auto_reload_i,
	input wire logic manual_update_i,
	input wire logic [CNT_W-1:0] count_buffer_i,
	input wire logic [CNT_W-1:0] compare_buffer_i,
	output logic [CNT_W-1:0] count_o,
	output logic tout_o,
	output logic zero_o
);
	logic [CNT_W-1:0] working_counter_reg;
	logic [CNT_W-1:0] working_compare_reg;
	logic [CNT_W-1:0] count_dec;
	logic tout_reg;
	logic zero_reg;
	logic step;
	logic reload;

	assign count_dec = working_counter_reg - 1'b1;
	assign step = run_i && tick_i && !manual_update_i;
	assign reload = step && (working_counter_reg == '0) && auto_reload_i;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			working_counter_reg <= '0;
		else if (manual_update_i)
			working_counter_reg <= count_buffer_i;
		else if (reload)
			working_counter_reg <= count_buffer_i;
		else if (step && working_counter_reg != '0)
			working_counter_reg <= count_dec;
	end

	// Timer without compare never stores one
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			working_compare_reg <= '0;
		else if (HAS_CMP && (manual_update_i || reload))
			working_compare_reg <= compare_buffer_i;
	end

	// ------------------------------------------------------------
	// Output and zero event
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tout_reg <= 1'b0;
		else if (manual_update_i || reload)
			tout_reg <= 1'b0;
		else if (step && working_counter_reg != '0 && count_dec == working_compare_reg)
			tout_reg <= 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			zero_reg <= 1'b0;
		else
			zero_reg <= step && (working_counter_reg == {{(CNT_W-1){1'b0}}, 1'b1});
	end

	assign count_o = working_counter_reg;
	assign tout_o = HAS_CMP ? tout_reg : 1'b0;
	assign zero_o = zero_reg;

	a_oneshot_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(working_counter_reg == '0 && !auto_reload_i && !manual_update_i) |=> working_counter_reg == '0)
		else $error("one-shot counter left zero");
	a_match_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(HAS_CMP && step && working_counter_reg != '0 && count_dec == working_compare_reg) |=> tout_o)
		else $error("output not high after compare match");
endmodule

// file: test/sptc_dma_irq_model.sv
// Purpose: Stand-in for the DMA and interrupt controllers
// Assumes: Request is a level held until acknowledged
// Notes: slow_i stretches the acknowledge delay
module sptc_dma_irq_model
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic dma_req_i,
	input wire logic [5:0] irq_i,
	input wire logic slow_i,
	output logic dma_ack_o,
	output logic [7:0] ack_count_o,
	output logic [7:0] irq_count_o [6]
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_reg;
	// -------------------------------------------
	// Acknowledge
	// -------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dma_ack_o <= 1'b0;
			wait_reg <= 4'h0;
			ack_count_o <= 8'h00;
		end
		else
		begin
			dma_ack_o <= 1'b0;
			// Ack in flight: wait for the request to drop
			if (!dma_req_i || dma_ack_o)
				wait_reg <= 4'h0;
			else if (wait_reg == (slow_i ? 4'h6 : 4'h1))
			begin
				dma_ack_o <= 1'b1;
				ack_count_o <= ack_count_o + 8'h01;
				wait_reg <= 4'h0;
			end
			else
				wait_reg <= wait_reg + 4'h1;
		end
	end
	// Interrupt pulses counted per timer
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 6; i++)
				irq_count_o[i] <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < 6; i++)
				irq_count_o[i] <= irq_count_o[i] + 8'(irq_i[i]);
		end
	end
endmodule

// file: test/tb_top.sv
// Purpose: Register and timer checks of the timer control block
// Assumes: 20 MHz clock, one-shot runs of eight ticks
// Notes: External clocks free run with periods 6 and 10
module tb_top
	import sptc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_n_i, wen, ren, external_timer_clock, eclk, ack, req, cpin, slow;
	logic [31:0] addr, wdat, rdat, v;
	logic [5:0] irq;
	logic [4:0] pin;
	logic [7:0] ack_count, ic, ac;
	logic [7:0] irq_count [6];
	int n_mismatch, cmp_count, cyc, e, k, n;
	int rn [10] = '{0, 1, 2, 3, 0, 1, 4, 4, 5, 5};
	int rc [10] = '{0, 1, 2, 3, 4, 7, 1, 4, 0, 5};
	int rt [10] = '{2, 4, 16, 32, 32, 32, 12, 6, 6, 10};

	sptc_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_data_i(wdat),
		.wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdat), .external_timer_clock_i(external_timer_clock),
		.external_clock_input_i(eclk), .dma_ack_i(ack), .dma_req_o(req), .irq_o(irq),
		.pwm_output_pin_o(pin), .complementary_pwm_output_o(cpin));
	sptc_dma_irq_model u_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .dma_req_i(req),
		.irq_i(irq), .slow_i(slow), .dma_ack_o(ack), .ack_count_o(ack_count), .irq_count_o(irq_count));

	always #25 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		e <= e + 1;
		external_timer_clock <= (e % 6) < 3;
		eclk <= (e % 10) < 5;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// -------------------------------------------
	// Tasks
	// -------------------------------------------
	task automatic tally_and_finish();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdat <= d;
		wen <= 1'b1;
		@(posedge clk_i);
		wen <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		ren <= 1'b1;
		@(posedge clk_i);
		ren <= 1'b0;
		@(negedge clk_i);
		d = rdat;
	endtask
	// Load 8 and compare 1, then start; the start write drops the update bit
	task automatic start(input int t, input logic [31:0] extra);
		logic [31:0] a;
		a = SPTC_OFS_CNTBUF0 + 32'(t) * SPTC_TIMER_STRIDE;
		wr(a, 32'h8);
		wr(a + 32'h4, 32'h1);
		wr(SPTC_OFS_CONTROL, 32'h1 << SPTC_UPD_BIT[t]);
		rd(a + 32'h8, v);
		chk("loaded", v, 32'h8);
		wr(SPTC_OFS_CONTROL, (32'h1 << SPTC_RUN_BIT[t]) | extra);
	endtask

	initial
	begin
		{clk_i, rst_n_i, wen, ren, slow, external_timer_clock, eclk} = 7'h00;
		{addr, wdat} = 64'h0;
		{n_mismatch, cmp_count, cyc, e} = 128'h0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			rd(SPTC_OFS_PRESCALE + 32'(4 * i), v);
			chk("reset", v, 32'h0);
		end
		wr(SPTC_OFS_PRESCALE, 32'hffffffff);
		rd(SPTC_OFS_PRESCALE, v);
		chk("prescale", v, 32'hffffffff);
		wr(SPTC_OFS_CONTROL, 32'hffffffff);
		rd(SPTC_OFS_CONTROL, v);
		chk("control", v, 32'h07ffff1f);
		wr(SPTC_OFS_CLKSEL, 32'hffffffff);
		rd(SPTC_OFS_CLKSEL, v);
		chk("clksel", v, 32'h0fffffff);
		rd(32'h01d500f0, v);
		chk("unmapped", v, 32'h0);
		wr(SPTC_OFS_CONTROL, 32'h0);
		wr(SPTC_OFS_PRESCALE, 32'h00020100);
		// -------------------------------------------
		// Tick rates per divider and clock source
		// -------------------------------------------
		for (int i = 0; i < 10; i++)
		begin
			n = rn[i];
			wr(SPTC_OFS_CLKSEL, 32'(rc[i]) << (4 * n));
			start(n, 32'h0);
			k = 0;
			while (k < 400)
			begin
				@(posedge clk_i);
				k++;
				if (irq[n] === 1'b1)
					break;
			end
			chk("tick", 32'(k >= 7 * rt[i] + 1 && k <= 8 * rt[i] + 5), 32'h1);
			rd(SPTC_OFS_CNTBUF0 + 32'(n) * SPTC_TIMER_STRIDE + 32'h8, v);
			chk("held", v, 32'h0);
			if (n < 5)
				chk("pin", pin[n], 1'b1);
			wr(SPTC_OFS_CONTROL, 32'h0);
		end
		// -------------------------------------------
		// DMA codes 0 to 7, ack prompt and slow
		// -------------------------------------------
		for (int d = 0; d < 8; d++)
		begin
			n = (d >= 1 && d <= 6) ? d - 1 : 0;
			slow <= d[0];
			wr(SPTC_OFS_CLKSEL, 32'(d) << 24);
			ic = irq_count[n];
			ac = ack_count;
			start(n, 32'h0);
			repeat (70) @(posedge clk_i);
			chk("irq", irq_count[n] - ic, (d >= 1 && d <= 6) ? 8'h0 : 8'h1);
			chk("ack", ack_count - ac, (d >= 1 && d <= 6) ? 8'h1 : 8'h0);
			chk("req", req, 1'b0);
		end
		// Interval mode, then stop
		// Period is count plus one ticks: 18 clocks, four zeros in the window
		wr(SPTC_OFS_CLKSEL, 32'h0);
		ic = irq_count[0];
		start(0, 32'h1 << SPTC_AR_BIT[0]);
		repeat (80) @(posedge clk_i);
		wr(SPTC_OFS_CONTROL, 32'h0);
		chk("reloads", irq_count[0] - ic, 8'h4);
		repeat (5) @(posedge clk_i);
		ic = irq_count[0];
		repeat (40) @(posedge clk_i);
		chk("stopped", irq_count[0], ic);
		// Dead zone routing and inversion on a finished one-shot
		start(0, 32'h0);
		repeat (30) @(posedge clk_i);
		wr(SPTC_OFS_CONTROL, 32'h1 << SPTC_DZ_EN_BIT);
		repeat (5) @(posedge clk_i);
		chk("dz0", pin, 5'h1d);
		chk("dzn", cpin, 1'b0);
		wr(SPTC_OFS_CONTROL, 32'h1 << SPTC_INV_BIT[0]);
		repeat (5) @(posedge clk_i);
		chk("inv", pin[0], 1'b0);
		chk("comp", cpin, 1'b1);
		tally_and_finish();
	end
endmodule
